/* File: core/decr_measure.sv */
`timescale 1ns/1ps
// Measurement engine: frame resolution, reference pixel colour, black/non-black counts
module decr_measure
	import decr_pkg::*;
#(
	parameter int LW = VLINE_W,
	parameter int PW = HCLK_W
) (
	input  wire logic          clock,
	input  wire logic          reset,
	input  wire logic          run,
	input  wire logic          vsync,
	input  wire logic          hsync,
	input  wire logic          pix_valid,
	input  wire logic [7:0]    pix_r,
	input  wire logic [7:0]    pix_g,
	input  wire logic [7:0]    pix_b,
	input  wire logic [LW-1:0] ref_line,
	input  wire logic [PW-1:0] ref_pixel,
	input  wire logic [7:0]    threshold,
	output logic      [LW-1:0] vlines,
	output logic      [PW-1:0] hclks,
	output logic      [7:0]    ref_r,
	output logic      [7:0]    ref_g,
	output logic      [7:0]    ref_b,
	output logic      [DARKLN_W-1:0] dark_lines,
	output logic      [DARKPX_W-1:0] dark_pixels,
	output logic      [LW-1:0] lit_lines,
	output logic      [PW-1:0] lit_pixels
);
	// Saturating increment, used by every counter
	function automatic logic [PW-1:0] sat_inc(input logic [PW-1:0] v, input logic [PW-1:0] max);
		sat_inc = (v == max) ? v : v + 1'b1;
	endfunction

	logic vs_d_r, hs_d_r, vs_nxt, hs_nxt;
	logic [LW-1:0] line_r, line_nxt, vl_nxt;
	logic [PW-1:0] pix_r_cnt, pix_nxt, hc_nxt;
	logic line_dark_r, line_dark_nxt, seen_lit_r, seen_lit_nxt;
	logic px_seen_lit_r, px_seen_lit_nxt;
	logic [DARKLN_W-1:0] dl_cnt_r, dl_cnt_nxt, dl_nxt;
	logic [DARKPX_W-1:0] dp_cnt_r, dp_cnt_nxt, dp_nxt;
	logic [LW-1:0] ll_cnt_r, ll_cnt_nxt, ll_nxt;
	logic [PW-1:0] lp_cnt_r, lp_cnt_nxt, lp_nxt;
	logic [7:0] rr_nxt, rg_nxt, rb_nxt;
	logic vs_rise, hs_rise, is_dark;

	assign vs_rise = vsync & ~vs_d_r;
	assign hs_rise = hsync & ~hs_d_r;
	// Black when every component sits at or below the threshold
	assign is_dark = (pix_r <= threshold) && (pix_g <= threshold) && (pix_b <= threshold); // [R05]

	// Next state of all counters and results
	always_comb begin
		vs_nxt = vsync;
		hs_nxt = hsync;
		line_nxt = line_r;
		pix_nxt = pix_r_cnt;
		vl_nxt = vlines;
		hc_nxt = hclks;
		line_dark_nxt = line_dark_r;
		seen_lit_nxt = seen_lit_r;
		px_seen_lit_nxt = px_seen_lit_r;
		dl_cnt_nxt = dl_cnt_r;
		dp_cnt_nxt = dp_cnt_r;
		ll_cnt_nxt = ll_cnt_r;
		lp_cnt_nxt = lp_cnt_r;
		dl_nxt = dark_lines;
		dp_nxt = dark_pixels;
		ll_nxt = lit_lines;
		lp_nxt = lit_pixels;
		rr_nxt = ref_r;
		rg_nxt = ref_g;
		rb_nxt = ref_b;
		if (run) begin
			if (pix_valid) begin
				pix_nxt = sat_inc(pix_r_cnt, {PW{1'b1}});
				// Reference pixel capture
				if (line_r == ref_line && pix_r_cnt == ref_pixel) begin // [R03] [R04]
					rr_nxt = pix_r;
					rg_nxt = pix_g;
					rb_nxt = pix_b;
				end
				if (is_dark) begin
					if (!px_seen_lit_r)
						dp_cnt_nxt = DARKPX_W'(sat_inc(PW'(dp_cnt_r), PW'({DARKPX_W{1'b1}}))); // [R07]
				end else begin
					px_seen_lit_nxt = 1'b1;
					lp_cnt_nxt = sat_inc(lp_cnt_r, {PW{1'b1}}); // [R09]
					line_dark_nxt = 1'b0;
				end
			end
			if (hs_rise) begin
				hc_nxt = pix_r_cnt; // [R02]
				dp_nxt = dp_cnt_r;
				lp_nxt = lp_cnt_r;
				pix_nxt = '0;
				dp_cnt_nxt = '0;
				lp_cnt_nxt = '0;
				px_seen_lit_nxt = 1'b0;
				line_nxt = LW'(sat_inc(PW'(line_r), PW'({LW{1'b1}})));
				line_dark_nxt = 1'b1;
				if (line_dark_r) begin
					if (!seen_lit_r)
						dl_cnt_nxt = DARKLN_W'(sat_inc(PW'(dl_cnt_r), PW'({DARKLN_W{1'b1}}))); // [R06]
				end else begin
					seen_lit_nxt = 1'b1;
					ll_cnt_nxt = LW'(sat_inc(PW'(ll_cnt_r), PW'({LW{1'b1}}))); // [R08]
				end
			end
			if (vs_rise) begin
				vl_nxt = line_r; // [R01]
				dl_nxt = dl_cnt_r;
				ll_nxt = ll_cnt_r;
				line_nxt = '0;
				dl_cnt_nxt = '0;
				ll_cnt_nxt = '0;
				seen_lit_nxt = 1'b0;
			end
		end
	end

	// Register all measurement state
	always_ff @(posedge clock) begin
		if (reset || !run) begin
			vs_d_r <= 1'b0;
			hs_d_r <= 1'b0;
			line_r <= '0;
			pix_r_cnt <= '0;
			line_dark_r <= 1'b1;
			seen_lit_r <= 1'b0;
			px_seen_lit_r <= 1'b0;
			dl_cnt_r <= '0;
			dp_cnt_r <= '0;
			ll_cnt_r <= '0;
			lp_cnt_r <= '0;
			vlines <= '0;
			hclks <= '0;
			dark_lines <= '0;
			dark_pixels <= '0;
			lit_lines <= '0;
			lit_pixels <= '0;
			ref_r <= '0;
			ref_g <= '0;
			ref_b <= '0;
		end else begin
			vs_d_r <= vs_nxt;
			hs_d_r <= hs_nxt;
			line_r <= line_nxt;
			pix_r_cnt <= pix_nxt;
			line_dark_r <= line_dark_nxt;
			seen_lit_r <= seen_lit_nxt;
			px_seen_lit_r <= px_seen_lit_nxt;
			dl_cnt_r <= dl_cnt_nxt;
			dp_cnt_r <= dp_cnt_nxt;
			ll_cnt_r <= ll_cnt_nxt;
			lp_cnt_r <= lp_cnt_nxt;
			vlines <= vl_nxt;
			hclks <= hc_nxt;
			dark_lines <= dl_nxt;
			dark_pixels <= dp_nxt;
			lit_lines <= ll_nxt;
			lit_pixels <= lp_nxt;
			ref_r <= rr_nxt;
			ref_g <= rg_nxt;
			ref_b <= rb_nxt;
		end
	end

	// Line count is latched on vsync rising edge
	a_vlines_latch: assert property (@(posedge clock) disable iff (reset) // [R01]
		run && $past(run) && vs_rise |=> vlines == $past(line_r))
		else $error("line count not latched at vsync");
	// Clock count is latched on hsync rising edge
	a_hclks_latch: assert property (@(posedge clock) disable iff (reset) // [R02]
		run && $past(run) && hs_rise |=> hclks == $past(pix_r_cnt))
		else $error("clock count not latched at hsync");
	// Reference red and blue captured at the reference position
	a_ref_capture: assert property (@(posedge clock) disable iff (reset) // [R04]
		run && pix_valid && line_r == ref_line && pix_r_cnt == ref_pixel
		|=> ref_r == $past(pix_r) && ref_b == $past(pix_b))
		else $error("reference pixel not captured");
	c_vsync_seen: cover property (@(posedge clock) run && vs_rise);
	c_ref_hit: cover property (@(posedge clock) run && pix_valid && line_r == ref_line);
	c_dark_px: cover property (@(posedge clock) run && pix_valid && is_dark);
endmodule // decr_measure

/* File: core/decr_pkg.sv */
// Package: subaddresses, field positions, reset values and widths of the register bank
package decr_pkg;
	localparam int DECR_AW = 8;
	localparam int DECR_DW = 8;
	localparam logic [7:0] SA_IRQ_STATE   = 8'h03;
	localparam logic [7:0] SA_VLINES_LO   = 8'h05;
	localparam logic [7:0] SA_VLINES_HI   = 8'h06;
	localparam logic [7:0] SA_HCLKS_LO    = 8'h07;
	localparam logic [7:0] SA_HCLKS_HI    = 8'h08;
	localparam logic [7:0] SA_REFLINE_LO  = 8'h09;
	localparam logic [7:0] SA_REFLINE_HI  = 8'h0A;
	localparam logic [7:0] SA_REFPIX_LO   = 8'h0B;
	localparam logic [7:0] SA_REFPIX_HI   = 8'h0C;
	localparam logic [7:0] SA_THRESH      = 8'h0D;
	localparam logic [7:0] SA_REF_RED     = 8'h0E;
	localparam logic [7:0] SA_REF_GREEN   = 8'h0F;
	localparam logic [7:0] SA_REF_BLUE    = 8'h10;
	localparam logic [7:0] SA_DARKLN      = 8'h11;
	localparam logic [7:0] SA_DARKPX_LO   = 8'h12;
	localparam logic [7:0] SA_DARKPX_HI   = 8'h13;
	localparam logic [7:0] SA_LITLN_LO    = 8'h14;
	localparam logic [7:0] SA_LITLN_HI    = 8'h15;
	localparam logic [7:0] SA_LITPX_LO    = 8'h16;
	localparam logic [7:0] SA_LITPX_HI    = 8'h17;
	localparam logic [7:0] SA_CFG_A       = 8'h18;
	localparam logic [7:0] SA_CFG_B       = 8'h19;
	localparam logic [7:0] SA_CLK_SEL     = 8'h1A;
	localparam logic [7:0] SA_PRE_P       = 8'h1B;
	localparam logic [7:0] SA_PRE_N       = 8'h1C;
	localparam logic [7:0] SA_PRE_OFS     = 8'h1D;
	localparam logic [7:0] SA_POST_P      = 8'h1E;
	localparam logic [7:0] SA_POST_N      = 8'h1F;
	localparam logic [7:0] SA_POST_OFS    = 8'h20;
	// Field positions in the first configuration register
	localparam int CFGA_PROC_RST = 0;
	localparam int CFGA_MEM_RST  = 1;
	localparam int CFGA_IN_RST   = 2;
	localparam int CFGA_MEM_INIT = 3;
	localparam int CFGA_NO_MEM   = 4;
	localparam int CFGA_ONE_ADC  = 5;
	localparam int CFGA_IRQ_ACK  = 6;
	// Field positions in the second configuration register
	localparam int CFGB_OUT_PD   = 0;
	localparam int CFGB_BLANK    = 1;
	localparam int CFGB_DITHER   = 2;
	localparam int CFGB_RGB_BYP  = 3;
	localparam int CFGB_YUV_CLK  = 4;
	// Field positions in the clock select register
	localparam int CLK_MEM_PLL   = 0;
	localparam int CLK_PNL_PLL   = 1;
	localparam int CLK_PLL_EN    = 2;
	localparam int CLK_POST_HALF = 3;
	localparam int CLK_PRE_HALF  = 4;
	localparam int CLK_POST_EN   = 5;
	localparam int CLK_PRE_EN    = 6;
	localparam int CLK_EXT_SYS   = 7;
	// Reset values
	localparam logic [7:0] CFGA_RST_VAL = 8'h07;
	localparam logic [7:0] CFGB_RST_VAL = 8'h00;
	localparam logic [7:0] CLK_RST_VAL  = 8'h00;
	localparam logic [7:0] REG_RST_VAL  = 8'h00;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00;
	// Measurement widths
	localparam int VLINE_W   = 11;
	localparam int HCLK_W    = 12;
	localparam int DARKLN_W  = 8;
	localparam int DARKPX_W  = 9;
endpackage

/* File: core/decr_top.sv */
`timescale 1ns/1ps
// Register bank of the display engine: measurements, configuration, clock selection
//
// Summary of operation
// R01: Count lines between vsyncs, 11 bits
// R02: Count clocks between hsyncs, 12 bits
// R03: Written line/pixel select reference location
// R04: Report reference pixel red, green, blue
// R05: Threshold colour classifies pixels black or not
// R06: Read black lines after vsync, 8 bits
// R07: Read black pixels after hsync, 9 bits
// R08: Read non-black lines after vsync, 11 bits
// R09: Read non-black pixels after hsync, 12 bits
// R10: Config A bits 0-2 hold paths reset
// R11: Config A bit 3 starts memory init
// R12: Bit 4 memory absent, bit 5 ADC count
// R13: Config A bit 6 acknowledges interrupt
// R14: Config B bit 0 powers output down
// R15: Config B bit 1 blanks the picture
// R16: Config B bit 2 enables temporal dithering
// R17: Config B bit 3 bypasses colour matrix
// R18: Config B bit 4 picks YUV clock
// R19: Clock bit 0 memory clock source
// R20: Panel clock source and PLL enables
// R21: Clock bit 7 external memory clock
// R22: Pre-divider counters and half precision
// R23: Post-divider counters and half precision
// R24: Low subaddress holds low byte
// R25: Interrupt state readable, active low
module decr_top
	import decr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	// Register port: one subaddress access per cycle
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// Video input, asynchronous to clock
	input  wire logic        vsync_pin,
	input  wire logic        hsync_pin,
	input  wire logic        pix_valid_pin,
	input  wire logic [7:0]  pix_r_pin,
	input  wire logic [7:0]  pix_g_pin,
	input  wire logic [7:0]  pix_b_pin,
	// Interrupt event from the engine core
	input  wire logic        irq_event,
	output logic             irq_n,
	// Path resets and memory control
	output logic             proc_path_rst,
	output logic             mem_path_rst,
	output logic             in_path_rst,
	output logic             mem_init_start,
	output logic             mem_absent,
	output logic             one_adc,
	// Output interface control
	output logic             out_power_down,
	output logic             blank_screen,
	output logic             dither_en,
	output logic             csc_bypass,
	output logic             yuv_clk_from_mclk,
	// Clock distribution
	output logic             mem_clk_from_pll,
	output logic             panel_clk_from_pll,
	output logic             pll_en,
	output logic             postdiv_half,
	output logic             prediv_half,
	output logic             postdiv_en,
	output logic             prediv_en,
	output logic             ext_mem_sys_clk,
	output logic      [7:0]  prediv_p,
	output logic      [7:0]  prediv_n,
	output logic      [3:0]  prediv_ofs,
	output logic      [7:0]  postdiv_p,
	output logic      [7:0]  postdiv_n,
	output logic      [3:0]  postdiv_ofs
);
	// Picks one byte of a multi-byte value: low subaddress holds bits 7..0
	function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi);
		byte_of = hi ? v[15:8] : v[7:0]; // [R24]
	endfunction

	logic [7:0] cfg_a_r, cfg_a_nxt, cfg_b_r, cfg_b_nxt, clk_r, clk_nxt;
	logic [7:0] pre_p_r, pre_p_nxt, pre_n_r, pre_n_nxt, post_p_r, post_p_nxt;
	logic [7:0] post_n_r, post_n_nxt, thresh_r, thresh_nxt;
	logic [3:0] pre_o_r, pre_o_nxt, post_o_r, post_o_nxt;
	logic [VLINE_W-1:0] refl_r, refl_nxt;
	logic [HCLK_W-1:0]  refp_r, refp_nxt;
	logic init_r, init_nxt, irq_r, irq_nxt;
	logic [7:0] rdata_nxt;
	logic vs_s1_r, vs_s2_r, hs_s1_r, hs_s2_r, pv_s1_r, pv_s2_r;
	logic [23:0] px_s1_r, px_s2_r;
	logic [VLINE_W-1:0] m_vlines, m_lit_lines;
	logic [HCLK_W-1:0]  m_hclks, m_lit_px;
	logic [7:0] m_r, m_g, m_b, m_dark_ln;
	logic [DARKPX_W-1:0] m_dark_px;
	logic wr_a, ack;

	// Two-flop synchronisers for the video input pins
	always_ff @(posedge clock) begin
		if (reset) begin
			vs_s1_r <= 1'b0;
			vs_s2_r <= 1'b0;
			hs_s1_r <= 1'b0;
			hs_s2_r <= 1'b0;
			pv_s1_r <= 1'b0;
			pv_s2_r <= 1'b0;
			px_s1_r <= '0;
			px_s2_r <= '0;
		end else begin
			vs_s1_r <= vsync_pin;
			vs_s2_r <= vs_s1_r;
			hs_s1_r <= hsync_pin;
			hs_s2_r <= hs_s1_r;
			pv_s1_r <= pix_valid_pin;
			pv_s2_r <= pv_s1_r;
			px_s1_r <= {pix_r_pin, pix_g_pin, pix_b_pin};
			px_s2_r <= px_s1_r;
		end
	end

	// Measurements run while the input path is out of reset
	decr_measure #(
		.LW (VLINE_W),
		.PW (HCLK_W)
	) u_measure (
		.clock       (clock),
		.reset       (reset),
		.run         (!in_path_rst),
		.vsync       (vs_s2_r),
		.hsync       (hs_s2_r),
		.pix_valid   (pv_s2_r),
		.pix_r       (px_s2_r[23:16]),
		.pix_g       (px_s2_r[15:8]),
		.pix_b       (px_s2_r[7:0]),
		.ref_line    (refl_r),
		.ref_pixel   (refp_r),
		.threshold   (thresh_r),
		.vlines      (m_vlines),
		.hclks       (m_hclks),
		.ref_r       (m_r),
		.ref_g       (m_g),
		.ref_b       (m_b),
		.dark_lines  (m_dark_ln),
		.dark_pixels (m_dark_px),
		.lit_lines   (m_lit_lines),
		.lit_pixels  (m_lit_px)
	);

	assign wr_a = reg_wr && reg_addr == SA_CFG_A;
	assign ack = wr_a && reg_wdata[CFGA_IRQ_ACK];

	// Write decode and interrupt / init pulse logic
	always_comb begin
		cfg_a_nxt = cfg_a_r;
		cfg_b_nxt = cfg_b_r;
		clk_nxt = clk_r;
		pre_p_nxt = pre_p_r;
		pre_n_nxt = pre_n_r;
		pre_o_nxt = pre_o_r;
		post_p_nxt = post_p_r;
		post_n_nxt = post_n_r;
		post_o_nxt = post_o_r;
		thresh_nxt = thresh_r;
		refl_nxt = refl_r;
		refp_nxt = refp_r;
		init_nxt = wr_a && reg_wdata[CFGA_MEM_INIT]; // [R11]
		// Event sets win over an acknowledge in the same cycle
		irq_nxt = irq_event ? 1'b1 : (ack ? 1'b0 : irq_r); // [R13]
		if (reg_wr) begin
			case (reg_addr)
				SA_CFG_A:      cfg_a_nxt = reg_wdata & ~(8'h01 << CFGA_IRQ_ACK); // [R10] [R12]
				SA_CFG_B:      cfg_b_nxt = reg_wdata; // [R14] [R15] [R16] [R17] [R18]
				SA_CLK_SEL:    clk_nxt = reg_wdata; // [R19] [R20] [R21]
				SA_PRE_P:      pre_p_nxt = reg_wdata; // [R22]
				SA_PRE_N:      pre_n_nxt = reg_wdata; // [R22]
				SA_PRE_OFS:    pre_o_nxt = reg_wdata[3:0]; // [R22]
				SA_POST_P:     post_p_nxt = reg_wdata; // [R23]
				SA_POST_N:     post_n_nxt = reg_wdata; // [R23]
				SA_POST_OFS:   post_o_nxt = reg_wdata[3:0]; // [R23]
				SA_THRESH:     thresh_nxt = reg_wdata; // [R05]
				SA_REFLINE_LO: refl_nxt[7:0] = reg_wdata; // [R03] [R24]
				SA_REFLINE_HI: refl_nxt[VLINE_W-1:8] = reg_wdata[VLINE_W-9:0]; // [R03]
				SA_REFPIX_LO:  refp_nxt[7:0] = reg_wdata; // [R03] [R24]
				SA_REFPIX_HI:  refp_nxt[HCLK_W-1:8] = reg_wdata[HCLK_W-9:0]; // [R03]
				default: ;
			endcase
		end
	end

	// Read mux, registered one cycle after the read strobe
	always_comb begin
		rdata_nxt = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				SA_IRQ_STATE: rdata_nxt = {7'h00, ~irq_r}; // [R25]
				SA_VLINES_LO: rdata_nxt = byte_of(16'(m_vlines), 1'b0); // [R01]
				SA_VLINES_HI: rdata_nxt = byte_of(16'(m_vlines), 1'b1); // [R01]
				SA_HCLKS_LO:  rdata_nxt = byte_of(16'(m_hclks), 1'b0); // [R02]
				SA_HCLKS_HI:  rdata_nxt = byte_of(16'(m_hclks), 1'b1); // [R02]
				SA_REF_RED:   rdata_nxt = m_r; // [R04]
				SA_REF_GREEN: rdata_nxt = m_g; // [R04]
				SA_REF_BLUE:  rdata_nxt = m_b; // [R04]
				SA_DARKLN:    rdata_nxt = m_dark_ln; // [R06]
				SA_DARKPX_LO: rdata_nxt = byte_of(16'(m_dark_px), 1'b0); // [R07]
				SA_DARKPX_HI: rdata_nxt = byte_of(16'(m_dark_px), 1'b1); // [R07]
				SA_LITLN_LO:  rdata_nxt = byte_of(16'(m_lit_lines), 1'b0); // [R08]
				SA_LITLN_HI:  rdata_nxt = byte_of(16'(m_lit_lines), 1'b1); // [R08]
				SA_LITPX_LO:  rdata_nxt = byte_of(16'(m_lit_px), 1'b0); // [R09]
				SA_LITPX_HI:  rdata_nxt = byte_of(16'(m_lit_px), 1'b1); // [R09]
				default:      rdata_nxt = UNMAPPED_VAL;
			endcase
		end
	end

	// Register state
	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_a_r <= CFGA_RST_VAL;
			cfg_b_r <= CFGB_RST_VAL;
			clk_r <= CLK_RST_VAL;
			pre_p_r <= REG_RST_VAL;
			pre_n_r <= REG_RST_VAL;
			pre_o_r <= 4'h0;
			post_p_r <= REG_RST_VAL;
			post_n_r <= REG_RST_VAL;
			post_o_r <= 4'h0;
			thresh_r <= REG_RST_VAL;
			refl_r <= '0;
			refp_r <= '0;
			init_r <= 1'b0;
			irq_r <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			cfg_a_r <= cfg_a_nxt;
			cfg_b_r <= cfg_b_nxt;
			clk_r <= clk_nxt;
			pre_p_r <= pre_p_nxt;
			pre_n_r <= pre_n_nxt;
			pre_o_r <= pre_o_nxt;
			post_p_r <= post_p_nxt;
			post_n_r <= post_n_nxt;
			post_o_r <= post_o_nxt;
			thresh_r <= thresh_nxt;
			refl_r <= refl_nxt;
			refp_r <= refp_nxt;
			init_r <= init_nxt;
			irq_r <= irq_nxt;
			reg_rdata <= rdata_nxt;
		end
	end

	// Control outputs straight from the register bits
	assign proc_path_rst = cfg_a_r[CFGA_PROC_RST]; // [R10]
	assign mem_path_rst = cfg_a_r[CFGA_MEM_RST]; // [R10]
	assign in_path_rst = cfg_a_r[CFGA_IN_RST]; // [R10]
	assign mem_init_start = init_r; // [R11]
	assign mem_absent = cfg_a_r[CFGA_NO_MEM]; // [R12]
	assign one_adc = cfg_a_r[CFGA_ONE_ADC]; // [R12]
	assign irq_n = ~irq_r; // [R13]
	assign out_power_down = cfg_b_r[CFGB_OUT_PD]; // [R14]
	assign blank_screen = cfg_b_r[CFGB_BLANK]; // [R15]
	assign dither_en = cfg_b_r[CFGB_DITHER]; // [R16]
	assign csc_bypass = cfg_b_r[CFGB_RGB_BYP]; // [R17]
	assign yuv_clk_from_mclk = cfg_b_r[CFGB_YUV_CLK]; // [R18]
	assign mem_clk_from_pll = clk_r[CLK_MEM_PLL]; // [R19]
	assign panel_clk_from_pll = clk_r[CLK_PNL_PLL]; // [R20]
	assign pll_en = clk_r[CLK_PLL_EN]; // [R20]
	assign postdiv_half = clk_r[CLK_POST_HALF]; // [R23]
	assign prediv_half = clk_r[CLK_PRE_HALF]; // [R22]
	assign postdiv_en = clk_r[CLK_POST_EN]; // [R20]
	assign prediv_en = clk_r[CLK_PRE_EN]; // [R20]
	assign ext_mem_sys_clk = clk_r[CLK_EXT_SYS]; // [R21]
	assign prediv_p = pre_p_r;
	assign prediv_n = pre_n_r;
	assign prediv_ofs = pre_o_r;
	assign postdiv_p = post_p_r;
	assign postdiv_n = post_n_r;
	assign postdiv_ofs = post_o_r;

	// Acknowledge without a new event returns the interrupt line high
	a_irq_ack: assert property (@(posedge clock) disable iff (reset) // [R13]
		ack && !irq_event |=> irq_n)
		else $error("interrupt not released by acknowledge");
	// Event pulls the interrupt line low next cycle, even against an acknowledge
	a_irq_set: assert property (@(posedge clock) disable iff (reset) // [R13]
		irq_event |=> !irq_n)
		else $error("interrupt not raised by event");
	// Event drives the interrupt low and holds it until acknowledged
	a_irq_hold: assert property (@(posedge clock) disable iff (reset) // [R13]
		irq_event ##1 !ack[*2] |=> !irq_n)
		else $error("interrupt dropped without acknowledge");
	// Status read reflects the interrupt line
	a_irq_read: assert property (@(posedge clock) disable iff (reset) // [R25]
		reg_rd && reg_addr == SA_IRQ_STATE |=> reg_rdata[0] == $past(irq_n))
		else $error("interrupt state read wrong");
	// Init request follows a write with bit 3 set
	a_init_pulse: assert property (@(posedge clock) disable iff (reset) // [R11]
		wr_a && reg_wdata[CFGA_MEM_INIT] |=> mem_init_start)
		else $error("init pulse missing");
	// Init pulse never appears without a write that asks for it
	a_init_single: assert property (@(posedge clock) disable iff (reset) // [R11]
		mem_init_start |-> $past(wr_a) && $past(reg_wdata[CFGA_MEM_INIT]))
		else $error("init pulse without request");
	// Path resets follow the written bits
	a_path_rst: assert property (@(posedge clock) disable iff (reset) // [R10]
		wr_a |=> {in_path_rst, mem_path_rst, proc_path_rst} == $past(reg_wdata[2:0]))
		else $error("path reset bits not taken");
	// Power-down bit follows a write
	a_power_down: assert property (@(posedge clock) disable iff (reset) // [R14]
		reg_wr && reg_addr == SA_CFG_B |=> out_power_down == $past(reg_wdata[CFGB_OUT_PD]))
		else $error("power down bit not taken");
	// Blanking, dithering, matrix bypass and YUV clock follow a write
	a_cfg_b_take: assert property (@(posedge clock) disable iff (reset) // [R15] [R16] [R17] [R18]
		reg_wr && reg_addr == SA_CFG_B |=> {yuv_clk_from_mclk, csc_bypass, dither_en,
			blank_screen} == $past(reg_wdata[CFGB_YUV_CLK:CFGB_BLANK]))
		else $error("second configuration bits not taken");
	// Clock select register drives the memory clock source
	a_mem_clk: assert property (@(posedge clock) disable iff (reset) // [R19]
		reg_wr && reg_addr == SA_CLK_SEL |=> mem_clk_from_pll == $past(reg_wdata[CLK_MEM_PLL]))
		else $error("memory clock select not taken");
	// Panel clock, PLL enables, precisions and external memory clock follow a write
	a_clk_take: assert property (@(posedge clock) disable iff (reset) // [R20] [R21]
		reg_wr && reg_addr == SA_CLK_SEL |=> {ext_mem_sys_clk, prediv_en, postdiv_en,
			prediv_half, postdiv_half, pll_en, panel_clk_from_pll} == $past(reg_wdata[7:1]))
		else $error("clock select bits not taken");
	// Pre-divider offset keeps only the low nibble of the write
	a_pre_div: assert property (@(posedge clock) disable iff (reset) // [R22]
		reg_wr && reg_addr == SA_PRE_OFS |=> prediv_ofs == $past(reg_wdata[3:0]))
		else $error("pre-divider offset not taken");
	// Post-divider offset keeps only the low nibble of the write
	a_post_div: assert property (@(posedge clock) disable iff (reset) // [R23]
		reg_wr && reg_addr == SA_POST_OFS |=> postdiv_ofs == $past(reg_wdata[3:0]))
		else $error("post-divider offset not taken");
	// Unmapped read returns zero
	a_unmapped_rd: assert property (@(posedge clock) disable iff (reset) // [R24]
		reg_rd && reg_addr == SA_CFG_A |=> reg_rdata == UNMAPPED_VAL)
		else $error("write-only read not zero");
	c_irq_ack: cover property (@(posedge clock) !irq_n ##1 ack);
	c_init: cover property (@(posedge clock) mem_init_start);
endmodule // decr_top

/* File: test/decr_testbench.sv */
`timescale 1ns/1ps
// Self-checking testbench for the display engine register bank
module testbench;
	import decr_pkg::*;
	logic        clock, reset, reg_wr, reg_rd, vs, hs, pv, irq_event;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, pr, pg, pb, pp, pn, qp, qn;
	logic [15:0] v;
	logic [3:0]  po, qo;
	logic        irq_n, init;
	wire  [4:0]  ca;
	wire  [4:0]  cb;
	wire  [7:0]  ck;
	int          err_total, cmp_count;

	decr_top u_dut (.clock(clock), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vsync_pin(vs),
		.hsync_pin(hs), .pix_valid_pin(pv), .pix_r_pin(pr), .pix_g_pin(pg), .pix_b_pin(pb),
		.irq_event(irq_event), .irq_n(irq_n), .proc_path_rst(ca[0]), .mem_path_rst(ca[1]),
		.in_path_rst(ca[2]), .mem_init_start(init), .mem_absent(ca[3]), .one_adc(ca[4]),
		.out_power_down(cb[0]), .blank_screen(cb[1]), .dither_en(cb[2]), .csc_bypass(cb[3]),
		.yuv_clk_from_mclk(cb[4]), .mem_clk_from_pll(ck[0]), .panel_clk_from_pll(ck[1]),
		.pll_en(ck[2]), .postdiv_half(ck[3]), .prediv_half(ck[4]), .postdiv_en(ck[5]),
		.prediv_en(ck[6]), .ext_mem_sys_clk(ck[7]), .prediv_p(pp), .prediv_n(pn),
		.prediv_ofs(po), .postdiv_p(qp), .postdiv_n(qn), .postdiv_ofs(qo));

	// Clock at 40 MHz
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Closing verdict
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Compare one result
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Register write, one cycle strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask

	// Register read, data taken the cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clock);
		reg_rd = 1'b1; reg_addr = a;
		@(negedge clock);
		reg_rd = 1'b0;
		d = {8'h00, reg_rdata};
	endtask

	// Two-byte read, upper byte from the higher subaddress
	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		logic [15:0] l, h;
		rd(a, l);
		rd(a + 8'h01, h);
		d = {h[7:0], l[7:0]};
	endtask

	// Sync pulse on the video pins
	task automatic sync(input logic vv, input logic hh);
		@(negedge clock);
		vs = vv; hs = hh;
		repeat (3) @(negedge clock);
		vs = 1'b0; hs = 1'b0;
		repeat (2) @(negedge clock);
	endtask

	// One line of five pixels, pixel 2 carries c
	task automatic line(input logic [7:0] c);
		sync(1'b0, 1'b1);
		for (int i = 0; i < 5; i++) begin
			@(negedge clock);
			pv = 1'b1;
			pr = (i < 2) ? 8'h00 : (i == 2) ? c : (c == 8'h00 ? 8'h00 : 8'h80);
			pg = (i == 2 && c != 8'h00) ? 8'h50 : pr;
			pb = (i == 2 && c != 8'h00) ? 8'h60 : pr;
		end
		@(negedge clock);
		pv = 1'b0;
	endtask

	task automatic t_reset();
		chk({6'h00, ca, cb}, {6'h00, 5'h07, 5'h00});
		chk({6'h00, ck, init, irq_n}, {6'h00, 8'h00, 1'b0, 1'b1});
		rd(SA_IRQ_STATE, v); chk(v, 16'h0001);
		rd(8'h21, v); chk(v, 16'h0000);
		$display("reset test done");
	endtask

	task automatic t_cfg();
		for (int i = 0; i < 5; i++) begin
			wr(SA_CFG_B, 8'h01 << i); chk(16'(cb), 16'h0001 << i);
		end
		rd(SA_CFG_B, v); chk(v, 16'h0000);
		wr(SA_CLK_SEL, 8'hA5); chk(16'(ck), 16'h00A5);
		wr(SA_CLK_SEL, 8'h5A); chk(16'(ck), 16'h005A);
		wr(SA_PRE_P, 8'h12); wr(SA_PRE_N, 8'h34); wr(SA_PRE_OFS, 8'hF7);
		wr(SA_POST_P, 8'hAB); wr(SA_POST_N, 8'hCD); wr(SA_POST_OFS, 8'h39);
		chk({pp, pn}, 16'h1234); chk({qp, qn}, 16'hABCD); chk(16'({po, qo}), 16'h0079);
		$display("config test done");
	endtask

	task automatic t_cfga();
		wr(SA_CFG_A, 8'h38);
		chk(16'(init), 16'h0001);
		@(negedge clock);
		chk(16'({init, ca}), 16'h0018);
		$display("cfga test done");
	endtask

	task automatic t_irq();
		@(negedge clock);
		irq_event = 1'b1;
		@(negedge clock);
		irq_event = 1'b0;
		chk(16'(irq_n), 16'h0000);
		rd(SA_IRQ_STATE, v); chk(v, 16'h0000);
		wr(SA_CFG_A, 8'h40); chk(16'(irq_n), 16'h0001);
		rd(SA_IRQ_STATE, v); chk(v, 16'h0001);
		// Event and acknowledge in one cycle: the event wins
		irq_event = 1'b1;
		wr(SA_CFG_A, 8'h40);
		irq_event = 1'b0;
		chk(16'(irq_n), 16'h0000);
		wr(SA_CFG_A, 8'h40); chk(16'(irq_n), 16'h0001);
		$display("interrupt test done");
	endtask

	task automatic t_meas();
		wr(SA_THRESH, 8'h10); wr(SA_REFLINE_LO, 8'h02); wr(SA_REFLINE_HI, 8'h00);
		wr(SA_REFPIX_LO, 8'h02); wr(SA_REFPIX_HI, 8'h00);
		sync(1'b1, 1'b0);
		line(8'h00); line(8'h40); line(8'h40);
		sync(1'b0, 1'b1); sync(1'b1, 1'b0);
		wr(SA_REF_RED, 8'hFF);
		rd16(SA_VLINES_LO, v); chk(v, 16'h0004);
		rd16(SA_HCLKS_LO, v); chk(v, 16'h0005);
		rd(SA_REF_RED, v); chk(v, 16'h0040);
		rd(SA_REF_GREEN, v); chk(v, 16'h0050);
		rd(SA_REF_BLUE, v); chk(v, 16'h0060);
		rd(SA_DARKLN, v); chk(v, 16'h0002);
		rd16(SA_DARKPX_LO, v); chk(v, 16'h0002);
		rd16(SA_LITLN_LO, v); chk(v, 16'h0002);
		rd16(SA_LITPX_LO, v); chk(v, 16'h0003);
		$display("measurement test done");
	endtask

	// Watchdog
	initial begin
		#400000;
		err_total++;
		final_report();
	end

	// Main sequence
	initial begin
		{reg_wr, reg_rd, vs, hs, pv, irq_event} = '0;
		{reg_addr, reg_wdata, pr, pg, pb} = '0;
		err_total = 0; cmp_count = 0;
		reset = 1'b1;
		repeat (2) @(negedge clock);
		reset = 1'b0;
		t_reset(); t_cfg(); t_cfga(); t_irq(); t_meas();
		final_report();
	end
endmodule // testbench
